// ### bench/aic_field_model.sv
`timescale 1ns/1ps
// ****************************************
// additive flow meter on the far side
// ****************************************
module aic_field_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       solenoid_out,
  input  wire logic [3:0] flow_gap,
  output logic            add_flow
);
  logic [3:0] cnt_r;
  // one-cycle meter pulse every flow_gap+1 cycles while the valve is open
  always_ff @(posedge sys_clk) begin
    if (rst || !solenoid_out) begin
      cnt_r    <= 4'h0;
      add_flow <= 1'b0;
    end else begin
      cnt_r    <= (cnt_r >= flow_gap) ? 4'h0 : cnt_r + 4'h1;
      add_flow <= cnt_r >= flow_gap;
    end
  end
endmodule : aic_field_model

// ### bench/aic_oc_asserts.sv
`timescale 1ns/1ps
// ****************************************
// output control checker
// ****************************************
module aic_oc_asserts #(
  parameter logic [19:0] FPO_PERIOD = 20'h14,
  parameter logic [35:0] MINUTE_CYC = 36'h32
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire aic_pkg::aic_apb_req_t apb_req,
  input wire aic_pkg::aic_apb_rsp_t apb_rsp,
  input wire aic_pkg::aic_pins_t    pins,
  input wire logic                  solenoid_out,
  input wire logic                  alarm_lamp,
  input wire logic                  shutdown_out,
  input wire logic                  valve_out,
  input wire logic                  ack_out,
  input wire logic                  pump_out,
  input wire logic                  fpo_out,
  input wire logic                  alarm_disp
);
  import aic_pkg::*;
  logic [31:0] ctl_r;
  logic [1:0]  age_r;
  logic [19:0] gap_r;
  logic        fpo_q;
  logic        ok;
  logic [3:0]  md;
  // shadow control word, its age, and cycles since the last scaled pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_r <= 32'h0;
      age_r <= 2'h0;
      gap_r <= 20'hfffff;
      fpo_q <= 1'b0;
    end else begin
      fpo_q <= fpo_out;
      gap_r <= (fpo_out && !fpo_q) ? 20'h1 : gap_r + 20'(gap_r != 20'hfffff);
      if (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
          && apb_req.paddr == 12'h000) begin
        ctl_r <= apb_req.pwdata;
        age_r <= 2'h0;
      end else if (age_r != 2'h3) begin
        age_r <= age_r + 2'h1;
      end
    end
  end
  assign ok = age_r == 2'h3;
  assign md = ctl_r[15:12];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_tank_held;
    pins.tank_empty [*6];
  endsequence
  sequence s_alarm_held;
    pins.alarm_in [*6] ##0 ok;
  endsequence
  sequence s_quiet_held;
    (!pins.tank_empty && !pins.alarm_in) [*6];
  endsequence
  sequence s_perm_clean;
    (pins.permissive && !pins.tank_empty && !pins.alarm_in) [*6] ##0 ok;
  endsequence

  a_tank_blocks: assert property (s_tank_held |-> !solenoid_out && alarm_disp)
    else $error("tank empty did not block");
  a_alarm_clears: assert property (s_quiet_held |-> !alarm_disp && !shutdown_out)
    else $error("alarm did not clear");
  a_lamp_alarm: assert property (s_alarm_held ##0 ctl_r[1] |-> alarm_lamp && alarm_disp)
    else $error("alarm lamp missing");
  a_shut_cause: assert property (ok && shutdown_out |-> ctl_r[7] && alarm_disp)
    else $error("shutdown without shutdown action");
  a_shut_stops: assert property (s_alarm_held ##0 ctl_r[7] |-> !solenoid_out && !valve_out)
    else $error("shutdown left flow running");
  a_valve_on: assert property (s_perm_clean ##0 ctl_r[3] |-> valve_out)
    else $error("block valve not open");
  a_valve_off: assert property ((!pins.permissive) [*6] |-> !valve_out)
    else $error("block valve open without permissive");
  a_ack_unbound: assert property (ok && !ctl_r[4] |-> !ack_out)
    else $error("unbound acknowledge active");
  a_ack_piston: assert property (ok && ctl_r[4] && md == 4'h0 |-> ack_out == solenoid_out)
    else $error("piston acknowledge differs");
  a_ack_inverted: assert property (ok && ctl_r[4] && md == 4'h1 |-> ack_out != solenoid_out)
    else $error("inverted acknowledge differs");
  a_post_pulse: assert property (ok && ctl_r[4] && md == 4'h2 && $fell(solenoid_out) |-> ack_out)
    else $error("post pulse missing");
  a_pump_start: assert property ($rose(pins.permissive) ##0 (ok && ctl_r[5]) |-> ##[2:5] pump_out)
    else $error("pump did not start");
  a_fpo_rate: assert property ($rose(fpo_out) |-> gap_r >= FPO_PERIOD)
    else $error("scaled pulses too close");
endmodule : aic_oc_asserts

bind aic_output_ctrl aic_oc_asserts #(.FPO_PERIOD(FPO_PERIOD), .MINUTE_CYC(MINUTE_CYC)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .pins(pins),
  .solenoid_out(solenoid_out), .alarm_lamp(alarm_lamp), .shutdown_out(shutdown_out),
  .valve_out(valve_out), .ack_out(ack_out), .pump_out(pump_out), .fpo_out(fpo_out),
  .alarm_disp(alarm_disp));

// ### bench/aic_output_ctrl_tb.sv
`timescale 1ns/1ps
// ****************************************
// output control bench
// ****************************************
module aic_output_ctrl_tb;
  import aic_pkg::*;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  aic_apb_req_t req = '0;
  aic_apb_rsp_t rsp;
  aic_pins_t    pin_r = '0;
  logic [15:0]  rtd = 16'h0;
  logic [15:0]  ain = 16'h0;
  logic [3:0]   gap = 4'h3;
  logic         flow, sol, lamp, shut, valve, ack, pump, fpo, disp, tval, se;
  logic         ack_q = 1'b0;
  logic         fpo_q = 1'b0;
  logic [15:0]  tv;
  logic [31:0]  rd;
  int           err_count = 0, compares = 0, cyc = 0, ack_chg = 0, fpo_cnt = 0, got_n;
  int           exp_chg [10] = '{2, 2, 2, 4, 2, 2, 2, 1, 1, 2};
  logic [11:0]  ra [4] = '{12'h000, 12'h004, 12'h008, 12'h00c};
  logic [31:0]  rv [4] = '{32'h0, 32'h3d090, 32'h64, 32'h5};

  always #2 sys_clk = ~sys_clk;

  aic_output_ctrl #(.FPO_PERIOD(20'h14), .MINUTE_CYC(36'h32)) dut (
    .sys_clk(sys_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .pins({pin_r[7:5], flow, pin_r[3:0]}),
    .resistance_thermometer_option_input(rtd), .optional_dc_analog_input(ain),
    .solenoid_out(sol), .alarm_lamp(lamp), .shutdown_out(shut), .valve_out(valve),
    .ack_out(ack), .pump_out(pump), .fpo_out(fpo), .alarm_disp(disp),
    .temp_value(tv), .temp_valid(tval));
  aic_field_model u_fld (.sys_clk(sys_clk), .rst(rst), .solenoid_out(sol),
    .flow_gap(gap), .add_flow(flow));

  // counts acknowledge changes, scaled pulses and run length
  always @(posedge sys_clk) begin
    cyc++;
    if (ack !== ack_q) ack_chg++;
    if (fpo === 1'b1 && fpo_q !== 1'b1) fpo_cnt++;
    ack_q <= ack;
    fpo_q <= fpo;
    if (cyc == 70000) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    @(posedge sys_clk);
    while (rsp.pready !== 1'b1) @(posedge sys_clk);
    rd = rsp.prdata;
    se = rsp.pslverr;
    req <= '0;
    // one idle edge, so the next request is not a second assignment now
    @(posedge sys_clk);
  endtask : apb

  task automatic pulse(input int b, input int n);
    pin_r[b] <= 1'b1;
    tick(n);
    pin_r[b] <= 1'b0;
  endtask : pulse

  // one injection, acknowledge changes counted over the window
  task automatic inject();
    @(negedge sys_clk) ack_chg = 0;
    @(posedge sys_clk);
    pulse(2, 3);
    tick(100);
    @(negedge sys_clk) got_n = ack_chg;
    @(posedge sys_clk);
  endtask : inject

  // main sequence
  initial begin
    void'($urandom(53569));
    rtd = 16'($urandom);
    ain = 16'($urandom);
    tick(3);
    rst <= 1'b0;
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 12'h100, 32'h0);
    chk({rd[30:0], se}, 32'h1);
    apb(1'b1, 12'h004, 32'h8);
    apb(1'b1, 12'h008, 32'h8);
    apb(1'b1, 12'h00c, 32'h1);
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, 12'h000, 32'h7f | (32'(t) << 8));
      tick(6);
      chk(tval, t != 0);
      if (t != 0) chk(tv, t == 1 ? rtd : ain);
    end
    pin_r.permissive <= 1'b1;
    for (int m = 0; m < 10; m++) begin
      apb(1'b1, 12'h000, 32'h7f | (32'(m) << 12));
      gap <= 4'(3 + $urandom % 3);
      tick(10);
      inject();
      chk(got_n, exp_chg[m]);
      chk(sol, 1'b0);
    end
    apb(1'b1, 12'h000, 32'h6f);
    tick(10);
    inject();
    chk(got_n, 0);
    apb(1'b1, 12'h000, 32'h7f);
    apb(1'b1, 12'h008, 32'h40);
    pulse(2, 3);
    tick(20);
    chk(sol, 1'b1);
    pulse(3, 3);
    tick(6);
    chk(sol, 1'b0);
    apb(1'b1, 12'h008, 32'h8);
    pin_r.permissive <= 1'b0;
    tick(8);
    chk({valve, pump}, 2'b01);
    repeat (3) begin
      tick(1 + $urandom % 25);
      pulse(5, 1);
    end
    tick(40);
    chk(pump, 1'b1);
    tick(25);
    chk(pump, 1'b0);
    pin_r.permissive <= 1'b1;
    tick(8);
    chk({valve, pump}, 2'b11);
    pin_r.alarm_in <= 1'b1;
    tick(8);
    chk({lamp, shut, disp}, 3'b101);
    pulse(2, 3);
    tick(8);
    chk(sol, 1'b1);
    pin_r.alarm_in <= 1'b0;
    apb(1'b1, 12'h000, 32'hff);
    tick(60);
    pulse(2, 3);
    tick(10);
    pin_r.alarm_in <= 1'b1;
    tick(8);
    chk({lamp, shut, disp, sol, valve}, 5'b11100);
    pulse(2, 3);
    tick(8);
    chk(sol, 1'b0);
    pin_r.alarm_in <= 1'b0;
    apb(1'b1, 12'h000, 32'h7f);
    pin_r.tank_empty <= 1'b1;
    tick(8);
    pulse(2, 3);
    tick(8);
    chk({disp, valve, sol}, 3'b100);
    pin_r.tank_empty <= 1'b0;
    tick(8);
    pulse(2, 3);
    tick(8);
    chk({disp, valve, sol}, 3'b011);
    tick(60);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 12'h000, 32'h7f | (32'(s) << 10));
      tick(10);
      @(negedge sys_clk) fpo_cnt = 0;
      @(posedge sys_clk);
      repeat (1000) begin
        pulse(6, 1);
        tick(1 + $urandom % 3);
      end
      tick(20 * (10 ** s) + 200);
      @(negedge sys_clk) got_n = fpo_cnt;
      @(posedge sys_clk);
      chk(got_n, 10 ** s);
    end
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
endmodule : aic_output_ctrl_tb

// ### logic/aic_consts.svh
`ifndef AIC_CONSTS_SVH
`define AIC_CONSTS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define AIC_CTRL_OFS    12'h000
`define AIC_DUR_OFS     12'h004
`define AIC_VOL_OFS     12'h008
`define AIC_TMO_OFS     12'h00c
`define AIC_STAT_OFS    12'h010
`define AIC_TEMP_OFS    12'h014
`define AIC_OWED_OFS    12'h018

// ****************************************
// control field positions
// ****************************************
`define AIC_B_SOL       0
`define AIC_B_LAMP      1
`define AIC_B_SHUT      2
`define AIC_B_VALVE     3
`define AIC_B_ACK       4
`define AIC_B_PUMP      5
`define AIC_B_FPO       6
`define AIC_B_ACTION    7
`define AIC_TSRC_LSB    8
`define AIC_TSRC_MSB    9
`define AIC_SCALE_LSB   10
`define AIC_SCALE_MSB   11
`define AIC_MODE_LSB    12
`define AIC_MODE_MSB    15

// ****************************************
// reset values
// ****************************************
`define AIC_CTRL_RST    32'h0000_0000
`define AIC_DUR_RST     32'h0003_d090
`define AIC_VOL_RST     16'h0064
`define AIC_TMO_RST     8'h05

// ****************************************
// timing
// ****************************************
`define AIC_CLK_HZ      250000000
`define AIC_FPO_MAX_HZ  300
`define AIC_MINUTE_S    60

`endif

// ### logic/aic_output_ctrl.sv
`timescale 1ns/1ps
`include "aic_consts.svh"
module aic_output_ctrl #(
  parameter logic [19:0] FPO_PERIOD =
    20'((`AIC_CLK_HZ + `AIC_FPO_MAX_HZ - 1) / `AIC_FPO_MAX_HZ),
  parameter logic [35:0] MINUTE_CYC = 36'(64'(`AIC_MINUTE_S) * 64'(`AIC_CLK_HZ))
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire aic_pkg::aic_apb_req_t apb_req,
  output aic_pkg::aic_apb_rsp_t      apb_rsp,
  input  wire aic_pkg::aic_pins_t    pins,
  input  wire logic [15:0]           resistance_thermometer_option_input,
  input  wire logic [15:0]           optional_dc_analog_input,
  output logic                       solenoid_out,
  output logic                       alarm_lamp,
  output logic                       shutdown_out,
  output logic                       valve_out,
  output logic                       ack_out,
  output logic                       pump_out,
  output logic                       fpo_out,
  output logic                       alarm_disp,
  output logic [15:0]                temp_value,
  output logic                       temp_valid
);
  import aic_pkg::*;

  aic_state_t    st_r;
  aic_state_t    st_nxt;
  logic          pg_start;
  logic          pg_hold;
  aic_ack_mode_t mode;
  logic [15:0]   q1;
  logic [15:0]   q2;
  logic [15:0]   q3;
  logic [15:0]   flow_inc;
  logic          hit_q1;
  logic          hit_q2;
  logic          hit_q3;
  logic          sol_fall;
  logic          sol_nxt;
  logic          trig_rise;
  logic          close_rise;
  logic          tick_rise;
  logic          vol_done;
  logic          blocked;
  logic          alarm;
  logic          perm;
  logic          perm_rise;
  logic          setup;
  logic          wr;
  logic [9:0]    div_max;

  // ****************************************
  // pulse timer for fixed-length acknowledge
  // ****************************************
  aic_pulse_tmr u_pulse (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (pg_start),
    .dur     (st_r.dur),
    .hold    (pg_hold)
  );

  // ****************************************
  // derived terms
  // ****************************************
  // volume marks of one injection
  assign mode     = aic_ack_mode_t'(st_r.ctrl[`AIC_MODE_MSB:`AIC_MODE_LSB]);
  assign q1       = {2'h0, st_r.vol[15:2]};
  assign q2       = {1'h0, st_r.vol[15:1]};
  assign q3       = st_r.vol - q1;
  assign flow_inc = st_r.flow + 16'h1;
  assign hit_q1   = st_r.sol && st_r.s3.add_flow && flow_inc == q1;
  assign hit_q2   = st_r.sol && st_r.s3.add_flow && flow_inc == q2;
  assign hit_q3   = st_r.sol && st_r.s3.add_flow && flow_inc == q3;
  // rising edges: second stage high while the third is still low
  assign trig_rise  = st_r.s2.inject_trig && !st_r.s3.inject_trig;
  assign close_rise = st_r.s2.close_req && !st_r.s3.close_req;
  assign tick_rise  = st_r.s2.dev_vol_tick && !st_r.s3.dev_vol_tick;
  // full volume reached on this meter pulse
  assign vol_done   = st_r.s3.add_flow && flow_inc >= st_r.vol;
  // solenoid decision kept outside the state process: the timer start
  // depends on the fall, and the state process reads the timer back
  assign sol_nxt  = perm && !blocked && st_r.ctrl[`AIC_B_SOL] &&
                    (st_r.sol ? !(close_rise || vol_done) : trig_rise);
  assign sol_fall = st_r.sol && !sol_nxt;
  // alarm sources: tank empty or the external alarm
  assign alarm    = st_r.s3.tank_empty || st_r.s3.alarm_in;
  assign blocked  = st_r.s3.tank_empty ||
                    (alarm && st_r.ctrl[`AIC_B_ACTION]);
  assign perm      = st_r.s3.permissive;
  assign perm_rise = st_r.s2.permissive && !st_r.s3.permissive;
  assign setup    = apb_req.psel && !apb_req.penable;
  assign wr       = apb_req.psel && apb_req.penable && apb_req.pwrite && st_r.rsp.pready;

  // scaled output divider: ticks are thousandths of a device unit
  // a scale of 10^n pulses per unit pays one pulse per 1000/10^n ticks
  always_comb begin
    unique case (st_r.ctrl[`AIC_SCALE_MSB:`AIC_SCALE_LSB])
      2'h0: div_max = 10'h3e7;
      2'h1: div_max = 10'h063;
      2'h2: div_max = 10'h009;
      2'h3: div_max = 10'h000;
    endcase
  end

  // acknowledge pulse starts per mode
  // the fixed-length and extended modes start the timer; the piston and end-sensor modes ignore it
  always_comb begin
    unique case (mode)
      ACK_POST:             pg_start = sol_fall;
      ACK_DOUBLE:           pg_start = hit_q1 || hit_q3;
      ACK_LAST:             pg_start = hit_q3;
      ACK_EXT, ACK_INV_EXT: pg_start = sol_fall;
      ACK_MID:              pg_start = hit_q2;
      default:              pg_start = 1'b0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt    = st_r;
    // pin synchroniser: two stages against metastability, a third for edges
    // a pin level reaches the outputs four edges after it changes
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;

    // register writes take effect in the access phase
    // status, temperature and owed count are read-only
    if (wr) begin
      unique case (apb_req.paddr)
        `AIC_CTRL_OFS: st_nxt.ctrl = apb_req.pwdata;
        `AIC_DUR_OFS:  st_nxt.dur  = apb_req.pwdata;
        `AIC_VOL_OFS:  st_nxt.vol  = apb_req.pwdata[15:0];
        `AIC_TMO_OFS:  st_nxt.tmo  = apb_req.pwdata[7:0];
        default: ;
      endcase
    end

    // ****************************************
    // transaction and solenoid
    // ****************************************
    // transaction follows permissive unless blocked
    st_nxt.txn = perm && !blocked;

    // solenoid open and close, volume count restarts on each opening
    st_nxt.sol = sol_nxt;
    if (!st_r.sol && sol_nxt) begin
      st_nxt.flow = 16'h0;
    end
    // meter pulses still in flight after the close are not counted
    if (st_r.sol && st_r.s3.add_flow) begin
      st_nxt.flow = flow_inc;
    end

    // ****************************************
    // alarm outputs
    // ****************************************
    // no latch, so they clear together with their cause
    // display flag and lamp in either action, shutdown only in shutdown
    st_nxt.disp = alarm;
    st_nxt.lamp = alarm && st_r.ctrl[`AIC_B_LAMP];
    st_nxt.shut = alarm && st_r.ctrl[`AIC_B_ACTION] &&
                  st_r.ctrl[`AIC_B_SHUT];

    // block valve
    st_nxt.valve = st_nxt.txn && st_r.ctrl[`AIC_B_VALVE];

    // ****************************************
    // injector acknowledge
    // ****************************************
    // end-sensor toggle on quarter volume of counted flow
    // the toggle state is kept across injections: one flip per start
    if (hit_q1) begin
      st_nxt.tog = !st_r.tog;
    end

    // acknowledge output per mode
    // codes above the mid-stroke mode keep it low
    unique case (mode)
      ACK_PISTON:     st_nxt.ack = st_nxt.sol;
      ACK_INV_PISTON: st_nxt.ack = !st_nxt.sol;
      ACK_EXT:        st_nxt.ack = st_nxt.sol || pg_start || pg_hold;
      ACK_INV_EXT:    st_nxt.ack = !(st_nxt.sol || pg_start || pg_hold);
      ACK_ENDS:       st_nxt.ack = st_nxt.tog;
      ACK_INV_ENDS:   st_nxt.ack = !st_nxt.tog;
      ACK_POST, ACK_DOUBLE, ACK_LAST, ACK_MID:
                      st_nxt.ack = pg_start || pg_hold;
      default:        st_nxt.ack = 1'b0;
    endcase
    if (!st_r.ctrl[`AIC_B_ACK]) begin
      st_nxt.ack = 1'b0;
    end

    // ****************************************
    // pump control
    // ****************************************
    // pump idle timer, restarted by wild stream pulses
    // the timer only runs with the permissive low; a zero timeout stops
    // the pump as soon as the permissive falls
    if (st_r.s3.wild_pulse || perm) begin
      st_nxt.pre  = 36'h0;
      st_nxt.mins = 8'h0;
    end else if (st_r.mins != st_r.tmo) begin
      if (st_r.pre >= MINUTE_CYC - 36'h1) begin
        st_nxt.pre  = 36'h0;
        st_nxt.mins = st_r.mins + 8'h1;
      end else begin
        st_nxt.pre = st_r.pre + 36'h1;
      end
    end
    if (!st_r.ctrl[`AIC_B_PUMP]) begin
      st_nxt.pump = 1'b0;
    end else if (perm_rise) begin
      st_nxt.pump = 1'b1;
    end else if (!perm && st_r.mins == st_r.tmo) begin
      st_nxt.pump = 1'b0;
    end

    // ****************************************
    // scaled pulse output
    // ****************************************
    // scaled pulse accumulation during the transaction, one step per tick
    if (st_r.txn && st_r.ctrl[`AIC_B_FPO] && tick_rise) begin
      if (st_r.div >= div_max) begin
        st_nxt.div  = 10'h0;
        st_nxt.owed = st_r.owed + 16'h1;
      end else begin
        st_nxt.div = st_r.div + 10'h1;
      end
    end
    // pay owed pulses no faster than the top rate
    // a burst of ticks only raises the owed count, the gap keeps the rate;
    // fpo is high for the upper half of each gap
    if (st_r.gap != 20'h0) begin
      st_nxt.gap = st_r.gap - 20'h1;
    end else if (st_nxt.owed != 16'h0) begin
      st_nxt.gap  = FPO_PERIOD - 20'h1;
      st_nxt.owed = st_nxt.owed - 16'h1;
    end
    st_nxt.fpo = st_r.ctrl[`AIC_B_FPO] && st_nxt.gap > (FPO_PERIOD >> 1);

    // ****************************************
    // temperature and register bus
    // ****************************************
    // temperature source select
    // the unused source code reads as no source
    unique case (aic_tsrc_t'(st_r.ctrl[`AIC_TSRC_MSB:`AIC_TSRC_LSB]))
      TSRC_RTD: begin
        st_nxt.temp = resistance_thermometer_option_input;
        st_nxt.tval = 1'b1;
      end
      TSRC_AI: begin
        st_nxt.temp = optional_dc_analog_input;
        st_nxt.tval = 1'b1;
      end
      default: begin
        st_nxt.temp = 16'h0;
        st_nxt.tval = 1'b0;
      end
    endcase

    // apb: data captured in setup, ready in the first access cycle
    // read data is taken in setup so that the access cycle needs no wait;
    // unmapped addresses answer with an error, writes to them are dropped
    st_nxt.rsp.pready  = setup;
    st_nxt.rsp.pslverr = 1'b0;
    if (setup) begin
      st_nxt.rsp.prdata = 32'h0;
      unique case (apb_req.paddr)
        `AIC_CTRL_OFS: st_nxt.rsp.prdata = st_r.ctrl;
        `AIC_DUR_OFS:  st_nxt.rsp.prdata = st_r.dur;
        `AIC_VOL_OFS:  st_nxt.rsp.prdata = {16'h0, st_r.vol};
        `AIC_TMO_OFS:  st_nxt.rsp.prdata = {24'h0, st_r.tmo};
        `AIC_STAT_OFS: st_nxt.rsp.prdata = {22'h0, st_r.tog, st_r.txn,
                         st_r.disp, st_r.fpo, st_r.pump, st_r.ack,
                         st_r.valve, st_r.shut, st_r.lamp, st_r.sol};
        `AIC_TEMP_OFS: st_nxt.rsp.prdata = {15'h0, st_r.tval, st_r.temp};
        `AIC_OWED_OFS: st_nxt.rsp.prdata = {16'h0, st_r.owed};
        default:       st_nxt.rsp.pslverr = 1'b1;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r      <= '0;
      st_r.ctrl <= `AIC_CTRL_RST;
      st_r.dur  <= `AIC_DUR_RST;
      st_r.vol  <= `AIC_VOL_RST;
      st_r.tmo  <= `AIC_TMO_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // outputs straight from the state register
  assign apb_rsp      = st_r.rsp;
  assign solenoid_out = st_r.sol;
  assign alarm_lamp   = st_r.lamp;
  assign shutdown_out = st_r.shut;
  assign valve_out    = st_r.valve;
  assign ack_out      = st_r.ack;
  assign pump_out     = st_r.pump;
  assign fpo_out      = st_r.fpo;
  assign alarm_disp   = st_r.disp;
  assign temp_value   = st_r.temp;
  assign temp_valid   = st_r.tval;
endmodule : aic_output_ctrl

// ### logic/aic_pkg.sv
package aic_pkg;

  // injector acknowledge modes
  typedef enum logic [3:0] {
    ACK_PISTON     = 4'h0,
    ACK_INV_PISTON = 4'h1,
    ACK_POST       = 4'h2,
    ACK_DOUBLE     = 4'h3,
    ACK_LAST       = 4'h4,
    ACK_EXT        = 4'h5,
    ACK_INV_EXT    = 4'h6,
    ACK_ENDS       = 4'h7,
    ACK_INV_ENDS   = 4'h8,
    ACK_MID        = 4'h9
  } aic_ack_mode_t;

  // temperature source
  typedef enum logic [1:0] {
    TSRC_NONE = 2'h0,
    TSRC_RTD  = 2'h1,
    TSRC_AI   = 2'h2
  } aic_tsrc_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } aic_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } aic_apb_rsp_t;

  // field pins, bit order used by the synchroniser
  typedef struct packed {
    logic alarm_in;
    logic dev_vol_tick;
    logic wild_pulse;
    logic add_flow;
    logic close_req;
    logic inject_trig;
    logic permissive;
    logic tank_empty;
  } aic_pins_t;

  typedef struct packed {
    logic [31:0] cnt;
  } aic_tmr_state_t;

  typedef struct packed {
    aic_pins_t   s1;
    aic_pins_t   s2;
    aic_pins_t   s3;
    logic [31:0] ctrl;
    logic [31:0] dur;
    logic [15:0] vol;
    logic [7:0]  tmo;
    logic        txn;
    logic        sol;
    logic        lamp;
    logic        shut;
    logic        valve;
    logic        ack;
    logic        pump;
    logic        fpo;
    logic        disp;
    logic        tog;
    logic [15:0] flow;
    logic [35:0] pre;
    logic [7:0]  mins;
    logic [9:0]  div;
    logic [15:0] owed;
    logic [19:0] gap;
    logic [15:0] temp;
    logic        tval;
    aic_apb_rsp_t rsp;
  } aic_state_t;

endpackage : aic_pkg

// ### logic/aic_pulse_tmr.sv
`timescale 1ns/1ps
// ****************************************
// fixed-length pulse timer
// ****************************************
module aic_pulse_tmr (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [31:0] dur,
  output logic             hold
);
  import aic_pkg::*;

  aic_tmr_state_t st_r;
  aic_tmr_state_t st_nxt;

  // load on start, count down to zero
  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.cnt = dur;
    end else if (st_r.cnt != 32'h0) begin
      st_nxt.cnt = st_r.cnt - 32'h1;
    end
  end

  // hold keeps the pulse up after its first cycle
  assign hold = (st_r.cnt > 32'h1);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : aic_pulse_tmr
